// ### core/ris_pkg.sv
// Package for the reset and interrupt sequencer: register map, field
// positions, vectors, start-up counts and the state types.
// Assumes a single 100 MHz bus clock and an APB master with 32-bit data.
package ris_pkg;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL        = 8'h00;
  localparam logic [7:0] REG_STATUS      = 8'h04;
  localparam logic [7:0] REG_TIMER_EN    = 8'h08;
  localparam logic [7:0] REG_SERIAL_CTRL = 8'h0C;
  localparam logic [7:0] REG_SERIAL_STAT = 8'h10;

  // Control register fields
  localparam int CTRL_WATCHDOG_ENABLE_BIT  = 0;
  localparam int CTRL_SLOW  = 1;
  localparam int CTRL_EXTEN = 4;
  localparam int CTRL_FALL  = 5;
  localparam int CTRL_RISE  = 6;
  localparam int CTRL_POR   = 7;

  // Status register fields
  localparam int STAT_MASK  = 0;
  localparam int STAT_WAIT  = 1;
  localparam int STAT_STOP  = 2;
  localparam int STAT_LATCH = 3;
  localparam int STAT_CAUSE = 4;

  // Serial control: enable in bit 0, interrupt enables in bits 7:4
  localparam int SCTL_ON = 0;
  localparam int SCTL_IE = 4;

  // Serial status flag positions
  localparam int SST_TX_REGISTER_EMPTY = 7;
  localparam int SST_TC   = 6;
  localparam int SST_OVR  = 5;
  localparam int SST_RX_REGISTER_FULL = 4;
  localparam int SST_IDLE = 3;
  localparam logic [4:0] SST_RESET = 5'h18;

  // Vectors (address of the high byte of each pair)
  localparam logic [15:0] VEC_RESET  = 16'h1FFE;
  localparam logic [15:0] VEC_SWI    = 16'h1FFC;
  localparam logic [15:0] VEC_EXT    = 16'h1FFA;
  localparam logic [15:0] VEC_CAP    = 16'h1FF8;
  localparam logic [15:0] VEC_CMP    = 16'h1FF6;
  localparam logic [15:0] VEC_OVF    = 16'h1FF4;
  localparam logic [15:0] VEC_SERIAL = 16'h1FF2;

  // Values loaded into neighbours on a full reset
  localparam logic [15:0] TIMER_LOAD = 16'hFFFC;
  localparam logic [15:0] STACK_INIT = 16'h00FF;

  // Counts in bus cycles, except the watchdog final count, which is in wdogTick pulses
  localparam logic [11:0] STARTUP_LONG_CYC  = 12'hFE0;
  localparam logic [11:0] STARTUP_SHORT_CYC = 12'h010;
  localparam logic [2:0]  RESET_DRIVE_CYC   = 3'h4;
  localparam logic [2:0]  WATCHDOG_ENABLE_BIT_FINAL        = 3'h7;

  typedef enum logic [1:0] {
    PWR_RUN   = 2'b00,
    PWR_WAIT  = 2'b01,
    PWR_STOP  = 2'b10,
    PWR_START = 2'b11
  } ris_pwr_t;

  typedef enum logic [1:0] {
    CAUSE_POR  = 2'b00,
    CAUSE_EXT  = 2'b01,
    CAUSE_WATCHDOG_ENABLE_BIT = 2'b10
  } ris_cause_t;

endpackage

// ### core/ris_sync.sv
// Two-flop synchroniser for pins that arrive from outside the clock domain.
// Assumes the bus clock and the synchronous active-low reset.
`timescale 1ns/100ps
module ris_sync #(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      meta_q <= INIT;
      dout   <= INIT;
    end
    else
    begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule // ris_sync

// ### core/ris_top.sv
// Reset and interrupt sequencer: reset kinds, low-power entry, watchdog,
// pin interrupt latch, priority and vector choice, APB register slave.
// Assumes rstn is the power-on reset; the core reports instruction
// boundaries and special instructions as one-cycle pulses on clk.
`timescale 1ns/100ps
// Notes on behaviour
// - Stop with watchdog enabled gives a watchdog reset instead of sleep.
// - That reset keeps oscillator running, no start-up delay, enable from option.
// - Wait option enabled: watchdog keeps counting in wait and can reset.
// - Wait option disabled: counter cleared and halted in wait, resumes after.
// - Full reset clears timer prescaler, loads counter FFFC, clears timer enables.
// - Full reset clears direction registers, stack to 00FF, fetches reset vector.
// - Full reset sets the mask; wait and stop entry clear it.
// - Power-on flag set only by power-on reset.
// - Full reset clears enables but sets pin enable; clears stop, wait, pin latches.
// - Full reset disables serial, clears its enables and flags but sets TX_REGISTER_EMPTY, TC.
// - Power-on and stop hold oscillator off and clear timer and serial clocks.
// - Full reset and stop: converter off, slow mode clear, watchdog enable restored.
// - Watchdog counter cleared on every reset, wait entry and stop entry.
// - Taking an interrupt pushes registers, then sets the mask.
// - Return from interrupt restores the mask from its stacked copy.
// - Interrupts wait for instruction end; taken only if unmasked and enabled.
// - Fixed order: reset, pin, capture, compare, overflow, serial; trap placed by its fetch time.
// - Software trap ignores the mask and uses vector 1FFC.
// - Trap follows interrupts pending at its fetch, precedes later ones.
// - Maskable vectors 1FFA, 1FF8, 1FF6, 1FF4, 1FF2.
// - Mask set blocks every maskable request; clearing it lets them through.
// - Pin latch cleared when its service starts; one new pulse can latch.
// - Writing one to watchdog enable enables and clears; zero does nothing.
// - Sensitivity: 00 fall plus low, 01 fall, 10 rise, 11 both edges.
// - Pin interrupt needs mask clear, enable set, selected condition met.
module ris_top
  import ris_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cfgWdogAtReset,
  input  wire logic        cfgWaitWdog,
  input  wire logic        cfgLongStartup,
  input  wire logic        extResetN,
  input  wire logic        irqPinN,
  output logic             resetPinOut,
  output logic             resetPinOe,
  input  wire logic        instrDone,
  input  wire logic        swiFetch,
  input  wire logic        rtiExec,
  input  wire logic        stackedMask,
  input  wire logic        cliExec,
  input  wire logic        seiExec,
  input  wire logic        waitExec,
  input  wire logic        stopExec,
  input  wire logic        wdogTick,
  input  wire logic        captureFlag,
  input  wire logic        compareFlag,
  input  wire logic        overflowFlag,
  input  wire logic [4:0]  serialSet,
  output logic             coreResetN,
  output logic             cpuHalt,
  output logic             intMask,
  output logic             pushRegs,
  output logic             vectorReq,
  output logic      [15:0] vectorAddr,
  output logic             sysInit,
  output logic             ctrlInit,
  output logic             oscOff,
  output logic             clkClear,
  output logic             slowMode,
  output logic      [2:0]  timerIrqEn,
  output logic             serialOn,
  output logic      [3:0]  serialIe,
  output logic      [4:0]  serialStat
);

  typedef struct packed {
    ris_pwr_t    pwr;
    logic [11:0] oscCnt;
    logic        cfgDone;
    logic        cfgWait;
    logic        cfgWdog;
    logic        wdogEn;
    logic [2:0]  wdogCnt;
    logic        slowMode;
    logic        extEn;
    logic        riseSel;
    logic        fallSel;
    logic        porFlag;
    logic        mask;
    logic        extLatch;
    logic        pinPrev;
    logic [2:0]  timerEn;
    logic        serialOn;
    logic [3:0]  serialIe;
    logic [4:0]  serialStat;
    logic        swiPend;
    logic [4:0]  snap;
    logic [2:0]  rstDrive;
    logic        pinOe;
    logic        rstPend;
    ris_cause_t  cause;
    logic        coreResetN;
    logic        cpuHalt;
    logic        oscOff;
    logic        clkClear;
    logic        vectorReq;
    logic [15:0] vectorAddr;
    logic        pushRegs;
    logic        sysInit;
    logic        ctrlInit;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ris_state_t;

  ris_state_t s_q;
  ris_state_t s_d;
  logic [1:0] pinSync;
  logic       extRstLive;
  logic       pinHigh;
  logic       edgeHit;
  logic       levelHit;
  logic       extReq;
  logic       serReq;
  logic [4:0] pend;
  logic [4:0] maskable;
  logic [4:0] snapHit;
  logic [4:0] pick;
  logic       fullReset;
  logic       wdogFire;
  logic       wdogRun;
  logic       wrEn;
  logic [7:0] ctrlRd;

  // Reset and pin interrupt pins are asynchronous to clk
  ris_sync #(
    .W    (2),
    .INIT (2'b11)
  ) u_pin_sync (
    .clk  (clk),
    .rstn (rstn),
    .din  ({extResetN, irqPinN}),
    .dout (pinSync)
  );

  assign extRstLive = ~pinSync[1];
  assign pinHigh    = pinSync[0];

  always_comb
  begin
    s_d           = s_q;
    s_d.vectorReq = 1'b0;
    s_d.pushRegs  = 1'b0;
    s_d.sysInit   = 1'b0;
    s_d.ctrlInit  = 1'b0;
    s_d.pready    = 1'b0;
    s_d.pslverr   = 1'b0;
    s_d.pinPrev   = pinHigh;

    // Pin sensitivity decode
    edgeHit = (s_q.riseSel & ~s_q.pinPrev & pinHigh) |
              ((~s_q.riseSel | s_q.fallSel) & s_q.pinPrev & ~pinHigh);
    levelHit = ~s_q.riseSel & ~s_q.fallSel & ~pinHigh;
    // Low level is not latched, only edges
    extReq = (s_q.extLatch | levelHit) & s_q.extEn;
    serReq = (s_q.serialStat[SST_TX_REGISTER_EMPTY] & s_q.serialIe[3]) |
             (s_q.serialStat[SST_TC] & s_q.serialIe[2]) |
             ((s_q.serialStat[SST_OVR] | s_q.serialStat[SST_RX_REGISTER_FULL]) & s_q.serialIe[1]) |
             (s_q.serialStat[SST_IDLE] & s_q.serialIe[0]);
    pend = {extReq, captureFlag & s_q.timerEn[2], compareFlag & s_q.timerEn[1],
            overflowFlag & s_q.timerEn[0], serReq};
    maskable = pend & {5{~s_q.mask}};
    snapHit  = s_q.snap & maskable;
    pick     = s_q.swiPend ? snapHit : maskable;

    // APB register access, zero wait states
    ctrlRd = {s_q.porFlag, s_q.riseSel, s_q.fallSel, s_q.extEn, 2'b00,
              s_q.slowMode, s_q.wdogEn};
    wrEn = psel & penable & pwrite & s_q.pready & ~s_q.pslverr;
    if (psel && !penable)
    begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h0000_0000;
      unique case (paddr)
        REG_CTRL:        s_d.prdata[7:0] = ctrlRd;
        REG_STATUS:      s_d.prdata[5:0] = {s_q.cause, s_q.extLatch, s_q.pwr == PWR_STOP,
                                            s_q.pwr == PWR_WAIT, s_q.mask};
        REG_TIMER_EN:    s_d.prdata[2:0] = s_q.timerEn;
        REG_SERIAL_CTRL: s_d.prdata[7:0] = {s_q.serialIe, 3'b000, s_q.serialOn};
        REG_SERIAL_STAT: s_d.prdata[7:0] = {s_q.serialStat, 3'b000};
        default:         s_d.pslverr = 1'b1;
      endcase
    end
    if (wrEn)
    begin
      unique case (paddr)
        REG_CTRL:
        begin
          if (pwdata[CTRL_WATCHDOG_ENABLE_BIT])
          begin
            s_d.wdogEn  = 1'b1;
            s_d.wdogCnt = 3'h0;
          end
          s_d.slowMode = pwdata[CTRL_SLOW];
          if (!pwdata[CTRL_POR])
            s_d.porFlag = 1'b0;
          // Options only change while masked to avoid spurious requests
          if (s_q.mask)
          begin
            s_d.extEn   = pwdata[CTRL_EXTEN];
            s_d.riseSel = pwdata[CTRL_RISE];
            s_d.fallSel = pwdata[CTRL_FALL];
            if (pwdata[CTRL_RISE] != s_q.riseSel || pwdata[CTRL_FALL] != s_q.fallSel)
              s_d.extLatch = 1'b0;
          end
        end
        REG_TIMER_EN:    s_d.timerEn = pwdata[2:0];
        REG_SERIAL_CTRL:
        begin
          s_d.serialOn = pwdata[SCTL_ON];
          s_d.serialIe = pwdata[SCTL_IE +: 4];
        end
        REG_SERIAL_STAT: s_d.serialStat = s_q.serialStat & ~pwdata[SST_IDLE +: 5];
        default:         s_d.serialOn = s_q.serialOn;
      endcase
    end
    s_d.serialStat = s_d.serialStat | serialSet;

    // Core mask instructions
    if (cliExec)
      s_d.mask = 1'b0;
    if (seiExec)
      s_d.mask = 1'b1;
    if (rtiExec)
      s_d.mask = stackedMask;

    // Trap fetch snapshots what is already pending
    if (swiFetch)
    begin
      s_d.swiPend = 1'b1;
      s_d.snap    = maskable;
    end

    // Service choice only at an instruction boundary
    if (instrDone && s_q.pwr == PWR_RUN && s_q.coreResetN)
    begin
      if (s_q.swiPend && snapHit == 5'h00)
      begin
        s_d.swiPend    = 1'b0;
        s_d.snap       = 5'h00;
        s_d.vectorAddr = VEC_SWI;
        s_d.pushRegs   = 1'b1;
        s_d.vectorReq  = 1'b1;
        s_d.mask       = 1'b1;
      end
      else if (pick != 5'h00)
      begin
        s_d.pushRegs  = 1'b1;
        s_d.vectorReq = 1'b1;
        s_d.mask      = 1'b1;
        if (pick[4])
        begin
          s_d.vectorAddr = VEC_EXT;
          s_d.extLatch   = 1'b0;
          s_d.snap[4]    = 1'b0;
        end
        else if (pick[3])
        begin
          s_d.vectorAddr = VEC_CAP;
          s_d.snap[3]    = 1'b0;
        end
        else if (pick[2])
        begin
          s_d.vectorAddr = VEC_CMP;
          s_d.snap[2]    = 1'b0;
        end
        else if (pick[1])
        begin
          s_d.vectorAddr = VEC_OVF;
          s_d.snap[1]    = 1'b0;
        end
        else
        begin
          s_d.vectorAddr = VEC_SERIAL;
          s_d.snap[0]    = 1'b0;
        end
      end
    end

    // Edge latched after the service and option-write clears in the same cycle; a full reset clears it afterwards
    if (edgeHit)
      s_d.extLatch = 1'b1;

    // Watchdog counting; halted in wait unless the option keeps it running
    wdogRun  = s_q.wdogEn && (s_q.pwr == PWR_RUN ||
               (s_q.pwr == PWR_WAIT && s_q.cfgWait));
    wdogFire = 1'b0;
    if (wdogRun && wdogTick && s_d.wdogCnt == s_q.wdogCnt)
    begin
      s_d.wdogCnt = s_q.wdogCnt + 3'h1;
      wdogFire    = (s_q.wdogCnt == WATCHDOG_ENABLE_BIT_FINAL - 3'h1);
    end

    // Low-power states
    unique case (s_q.pwr)
      PWR_RUN:
      begin
        if (waitExec && s_q.coreResetN)
        begin
          s_d.pwr     = PWR_WAIT;
          s_d.mask    = 1'b0;
          s_d.wdogCnt = 3'h0;
        end
        else if (stopExec && s_q.coreResetN && !s_q.wdogEn)
        begin
          s_d.pwr      = PWR_STOP;
          s_d.mask     = 1'b0;
          s_d.wdogCnt  = 3'h0;
          s_d.wdogEn   = s_q.cfgWdog;
          s_d.slowMode = 1'b0;
          s_d.ctrlInit = 1'b1;
          s_d.oscOff   = 1'b1;
          s_d.clkClear = 1'b1;
        end
      end
      PWR_WAIT:
      begin
        if (pend != 5'h00)
          s_d.pwr = PWR_RUN;
      end
      PWR_STOP:
      begin
        if (extReq)
        begin
          s_d.pwr    = PWR_START;
          s_d.oscCnt = STARTUP_LONG_CYC - 12'h001;
        end
      end
      PWR_START:
      begin
        if (s_q.oscCnt != 12'h000)
          s_d.oscCnt = s_q.oscCnt - 12'h001;
        else
        begin
          s_d.pwr      = PWR_RUN;
          s_d.oscOff   = 1'b0;
          s_d.clkClear = 1'b0;
        end
      end
    endcase

    // Reset-class events dominate everything above
    fullReset = !s_q.cfgDone || extRstLive || wdogFire ||
                (stopExec && s_q.wdogEn && s_q.pwr == PWR_RUN && s_q.coreResetN);
    if (fullReset)
    begin
      s_d.rstPend    = 1'b1;
      s_d.coreResetN = 1'b0;
      s_d.mask       = 1'b1;
      s_d.extEn      = 1'b1;
      s_d.riseSel    = 1'b0;
      s_d.fallSel    = 1'b0;
      s_d.extLatch   = 1'b0;
      s_d.timerEn    = 3'h0;
      s_d.serialOn   = 1'b0;
      s_d.serialIe   = 4'h0;
      s_d.serialStat = SST_RESET;
      s_d.swiPend    = 1'b0;
      s_d.snap       = 5'h00;
      s_d.slowMode   = 1'b0;
      s_d.wdogCnt    = 3'h0;
      s_d.wdogEn     = s_q.cfgDone ? s_q.cfgWdog : cfgWdogAtReset;
      s_d.sysInit    = 1'b1;
      s_d.ctrlInit   = 1'b1;
      s_d.vectorReq  = 1'b0;
      s_d.pushRegs   = 1'b0;
      if (s_q.pwr != PWR_START)
      begin
        // Reset out of stop restarts the clocks at once
        s_d.pwr      = PWR_RUN;
        s_d.oscOff   = 1'b0;
        s_d.clkClear = 1'b0;
      end
      if (!s_q.cfgDone)
      begin
        // Options are straps: caught once after power-on release
        s_d.cfgDone  = 1'b1;
        s_d.cfgWait  = cfgWaitWdog;
        s_d.cfgWdog  = cfgWdogAtReset;
        s_d.porFlag  = 1'b1;
        s_d.cause    = CAUSE_POR;
        s_d.rstDrive = RESET_DRIVE_CYC;
        s_d.pwr      = PWR_START;
        s_d.oscOff   = 1'b1;
        s_d.clkClear = 1'b1;
        s_d.oscCnt   = (cfgLongStartup ? STARTUP_LONG_CYC : STARTUP_SHORT_CYC)
                       - 12'h001;
      end
      else if (extRstLive)
        s_d.cause = CAUSE_EXT;
      else
      begin
        // Watchdog reset leaves the oscillator alone, drives the pin
        s_d.cause    = CAUSE_WATCHDOG_ENABLE_BIT;
        s_d.rstDrive = RESET_DRIVE_CYC;
      end
    end
    else
    begin
      if (s_q.rstDrive != 3'h0)
        s_d.rstDrive = s_q.rstDrive - 3'h1;
      if (s_q.rstPend && s_q.rstDrive == 3'h0 && s_q.pwr != PWR_START)
      begin
        s_d.rstPend    = 1'b0;
        s_d.coreResetN = 1'b1;
        s_d.vectorReq  = 1'b1;
        s_d.vectorAddr = VEC_RESET;
      end
    end
    s_d.cpuHalt = (s_d.pwr != PWR_RUN);
    s_d.pinOe   = (s_d.rstDrive != 3'h0);
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign prdata      = s_q.prdata;
  assign pready      = s_q.pready;
  assign pslverr     = s_q.pslverr;
  assign resetPinOut = 1'b0;
  assign resetPinOe  = s_q.pinOe;
  assign coreResetN  = s_q.coreResetN;
  assign cpuHalt     = s_q.cpuHalt;
  assign intMask     = s_q.mask;
  assign pushRegs    = s_q.pushRegs;
  assign vectorReq   = s_q.vectorReq;
  assign vectorAddr  = s_q.vectorAddr;
  assign sysInit     = s_q.sysInit;
  assign ctrlInit    = s_q.ctrlInit;
  assign oscOff      = s_q.oscOff;
  assign clkClear    = s_q.clkClear;
  assign slowMode    = s_q.slowMode;
  assign timerIrqEn  = s_q.timerEn;
  assign serialOn    = s_q.serialOn;
  assign serialIe    = s_q.serialIe;
  assign serialStat  = s_q.serialStat;

endmodule // ris_top

// ### test/ris_top_chk.sv
// Checker for the sequencer's core-side ports.
// Assumes one clock and rstn as synchronous active-low reset.
`timescale 1ns/100ps
module ris_top_chk
  import ris_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        instrDone,
  input wire logic        waitExec,
  input wire logic        rtiExec,
  input wire logic        stackedMask,
  input wire logic        coreResetN,
  input wire logic        cpuHalt,
  input wire logic        intMask,
  input wire logic        pushRegs,
  input wire logic        vectorReq,
  input wire logic [15:0] vectorAddr,
  input wire logic        sysInit,
  input wire logic        ctrlInit,
  input wire logic        clkClear,
  input wire logic        slowMode,
  input wire logic        resetPinOut,
  input wire logic        resetPinOe,
  input wire logic        oscOff,
  input wire logic        serialOn,
  input wire logic [3:0]  serialIe,
  input wire logic [4:0]  serialStat,
  input wire logic [2:0]  timerIrqEn
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_push; pushRegs |-> vectorReq && intMask; endproperty
  a_push: assert property (p_push) else $error("push without vector");
  property p_done; pushRegs |-> $past(instrDone); endproperty
  a_done: assert property (p_done) else $error("take off boundary");
  property p_rstv; $rose(coreResetN) |-> vectorReq && vectorAddr == VEC_RESET; endproperty
  a_rstv: assert property (p_rstv) else $error("bad reset vector");
  property p_rstm; $rose(coreResetN) |-> intMask; endproperty
  a_rstm: assert property (p_rstm) else $error("mask clear at reset");
  property p_wait; waitExec && !cpuHalt && coreResetN && !instrDone |=> cpuHalt && !intMask;
  endproperty
  a_wait: assert property (p_wait) else $error("wait entry wrong");
  property p_rti; rtiExec && !instrDone |=> intMask == $past(stackedMask); endproperty
  a_rti: assert property (p_rti) else $error("mask not restored");
  property p_mask; pushRegs && vectorAddr != VEC_SWI |-> !$past(intMask); endproperty
  a_mask: assert property (p_mask) else $error("masked request taken");
  property p_init;
    sysInit |-> ##[0:1] (serialStat == SST_RESET && !serialOn && serialIe == 4'h0
      && timerIrqEn == 3'h0);
  endproperty
  a_init: assert property (p_init) else $error("reset state wrong");
  property p_osc; oscOff |-> cpuHalt; endproperty
  a_osc: assert property (p_osc) else $error("runs with oscillator off");
  property p_clk; oscOff == clkClear; endproperty
  a_clk: assert property (p_clk) else $error("clock clear apart from oscillator");
  property p_ctrl; sysInit |-> ctrlInit && !slowMode; endproperty
  a_ctrl: assert property (p_ctrl) else $error("control init missed");
  property p_pin; resetPinOe |-> !coreResetN && !resetPinOut; endproperty
  a_pin: assert property (p_pin) else $error("pin driven while core runs");
  c_ext: cover property (pushRegs && vectorAddr == VEC_EXT);
  c_rst: cover property ($rose(coreResetN));
  c_wait: cover property (waitExec && !cpuHalt);
endmodule // ris_top_chk

bind ris_top ris_top_chk u_chk (.clk, .rstn, .instrDone, .waitExec, .rtiExec, .stackedMask,
  .coreResetN, .cpuHalt, .intMask, .pushRegs, .vectorReq, .vectorAddr, .sysInit, .oscOff,
  .serialOn, .serialIe, .serialStat, .timerIrqEn, .ctrlInit, .clkClear, .slowMode,
  .resetPinOut, .resetPinOe);

// ### test/ris_core_model.sv
// Core model: ends an instruction every fourth running cycle, stacks mask.
// Assumes the sequencer's core-side pulses on the same clock.
`timescale 1ns/100ps
module ris_core_model (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic coreResetN,
  input  wire logic cpuHalt,
  input  wire logic pushRegs,
  input  wire logic intMask,
  output logic      instrDone = 1'b0,
  output logic      stackedMask = 1'b1
);
  logic [1:0] gapQ = 2'h0;
  logic       maskQ = 1'b1;
  // Gaps leave requests pending across instruction ends
  always @(posedge clk)
  begin
    maskQ <= intMask;
    gapQ <= (!rstn || !coreResetN || cpuHalt) ? 2'h0 : gapQ + 2'h1;
    instrDone <= rstn && coreResetN && !cpuHalt && gapQ == 2'h3;
    if (!rstn)
      stackedMask <= 1'b1;
    else if (pushRegs)
      stackedMask <= maskQ;
  end
endmodule // ris_core_model

// ### test/test_reset_interrupt_sequencer.sv
// Bench: resets, priorities, wait, watchdog, registers over APB.
// Assumes ris_top, the core model and the bound checker.
`timescale 1ns/100ps
module test_reset_interrupt_sequencer
  import ris_pkg::*;
;
  logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        extResetN = 1'b1, irqPinN = 1'b1, swiFetch = 1'b0, rtiExec = 1'b0;
  logic        cliExec = 1'b0, waitExec = 1'b0, stopExec = 1'b0, wdogTick = 1'b0;
  logic        pready, pslverr, resetPinOut, resetPinOe, coreResetN, cpuHalt, intMask;
  logic        pushRegs, vectorReq, sysInit, ctrlInit, oscOff, clkClear, slowMode;
  logic        serialOn, instrDone, stackedMask;
  logic        cfgWdogAtReset = 1'b0, cfgWaitWdog = 1'b0, cfgLongStartup = 1'b0;
  logic [2:0]  tfl = 3'h0, timerIrqEn;
  logic [3:0]  serialIe;
  logic [4:0]  serialSet = 5'h00, serialStat;
  logic [7:0]  paddr = 8'h00;
  logic [15:0] vectorAddr, ve;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [15:0] qv[$];
  logic [32:0] qr[$];
  int          n_fail = 0, comparisons = 0;
  localparam logic [15:0] VT[5] = '{VEC_EXT, VEC_CAP, VEC_CMP, VEC_OVF, VEC_SERIAL};
  ris_top dut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .cfgWdogAtReset, .cfgWaitWdog, .cfgLongStartup, .extResetN,
    .irqPinN, .resetPinOut, .resetPinOe, .instrDone, .swiFetch, .rtiExec, .stackedMask,
    .cliExec, .seiExec(1'b0), .waitExec, .stopExec, .wdogTick, .captureFlag(tfl[2]),
    .compareFlag(tfl[1]), .overflowFlag(tfl[0]), .serialSet, .coreResetN, .cpuHalt,
    .intMask, .pushRegs, .vectorReq, .vectorAddr, .sysInit, .ctrlInit, .oscOff, .clkClear,
    .slowMode, .timerIrqEn, .serialOn, .serialIe, .serialStat);
  ris_core_model core (.clk, .rstn, .coreResetN, .cpuHalt, .pushRegs, .intMask,
    .instrDone, .stackedMask);
  always #5 clk = ~clk;
  task automatic test_done;
    $display("comparisons %0d, n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Empty queue on a vector means an unexpected take
  always @(posedge clk)
  begin
    if (vectorReq)
    begin
      ve = qv.size() != 0 ? qv.pop_front() : 16'hXXXX;
      cmp({17'h0, vectorAddr}, {17'h0, ve});
    end
    if (psel && penable && pready && !pwrite)
      cmp({pslverr, prdata}, qr.pop_front());
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [32:0] d);
    int i;
    if (!w)
      qr.push_back(d);
    @(posedge clk) psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d[31:0] : 32'h0;
    @(posedge clk) penable <= 1'b1;
    for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge clk);
    if (i == 20)
    begin
      n_fail++;
      test_done();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic drain(input int lim);
    int i;
    for (i = 0; i < lim && qv.size() != 0; i++) @(posedge clk);
    if (qv.size() != 0)
    begin
      n_fail++;
      test_done();
    end
  endtask
  task automatic pin;
    @(posedge clk) irqPinN <= 1'b0;
    repeat (4) @(posedge clk);
    irqPinN <= 1'b1;
  endtask
  initial
  begin
    r = $urandom(32'h3446A7CA);
    qv.push_back(VEC_RESET);
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    drain(200);
    bus(0, REG_CTRL, 33'h90);
    bus(0, REG_STATUS, 33'h01);
    bus(0, 8'h14, 33'h100000000);
    r = $urandom;
    bus(1, REG_TIMER_EN, {1'b0, r});
    bus(0, REG_TIMER_EN, {30'h0, r[2:0]});
    bus(1, REG_TIMER_EN, 33'h7);
    bus(1, REG_SERIAL_CTRL, 33'h11);
    @(posedge clk) serialSet <= 5'h01;
    tfl <= 3'h7;
    @(posedge clk) serialSet <= 5'h00;
    pin();
    qv.push_back(VEC_SWI);
    @(posedge clk) swiFetch <= 1'b1;
    @(posedge clk) swiFetch <= 1'b0;
    drain(50);
    for (int k = 0; k < 5; k++)
    begin
      qv.push_back(VT[k]);
      @(posedge clk) cliExec <= !k[0];
      rtiExec <= k[0];
      @(posedge clk) cliExec <= 1'b0;
      rtiExec <= 1'b0;
      drain(50);
      if (k > 0 && k < 4)
        tfl <= tfl & ~(3'h4 >> (k - 1));
      if (k == 4)
        bus(1, REG_SERIAL_CTRL, 33'h0);
    end
    qv.push_back(VEC_EXT);
    @(posedge clk) waitExec <= 1'b1;
    @(posedge clk) waitExec <= 1'b0;
    pin();
    drain(50);
    bus(1, REG_CTRL, 33'h01);
    qv.push_back(VEC_RESET);
    @(posedge clk) wdogTick <= 1'b1;
    repeat (7) @(posedge clk);
    wdogTick <= 1'b0;
    drain(100);
    bus(0, REG_STATUS, 33'h21);
    bus(1, REG_CTRL, 33'h01);
    qv.push_back(VEC_RESET);
    @(posedge clk) stopExec <= 1'b1;
    @(posedge clk) stopExec <= 1'b0;
    drain(100);
    bus(0, REG_CTRL, 33'h10);
    bus(1, REG_CTRL, 33'h0);
    qv.push_back(VEC_RESET);
    @(posedge clk) extResetN <= 1'b0;
    repeat (5) @(posedge clk);
    extResetN <= 1'b1;
    drain(100);
    bus(0, REG_CTRL, 33'h10);
    // Second power-on with the other strap values
    cfgWdogAtReset <= 1'b1;
    cfgWaitWdog <= 1'b1;
    cfgLongStartup <= 1'b1;
    rstn <= 1'b0;
    qv.push_back(VEC_RESET);
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    drain(4200);
    bus(0, REG_CTRL, 33'h91);
    bus(1, REG_TIMER_EN, 33'h1);
    tfl <= 3'h1;
    qv.push_back(VEC_OVF);
    qv.push_back(VEC_SWI);
    @(posedge clk) cliExec <= 1'b1;
    @(posedge clk) cliExec <= 1'b0;
    swiFetch <= 1'b1;
    @(posedge clk) swiFetch <= 1'b0;
    drain(50);
    tfl <= 3'h0;
    qv.push_back(VEC_RESET);
    @(posedge clk) waitExec <= 1'b1;
    @(posedge clk) waitExec <= 1'b0;
    wdogTick <= 1'b1;
    repeat (7) @(posedge clk);
    wdogTick <= 1'b0;
    drain(100);
    bus(0, REG_STATUS, 33'h21);
    bus(0, REG_CTRL, 33'h91);
    test_done();
  end
endmodule // test_reset_interrupt_sequencer
